// ==== drof_pkg.sv ====
// Package with register map, function codes and timing constants for the relay output block
package drof_pkg;

    // Register byte addresses
    localparam logic [7:0] ADDR_FUNC_SEL    = 8'h00;
    localparam logic [7:0] ADDR_CTRL        = 8'h04;
    localparam logic [7:0] ADDR_LIMIT_ONE   = 8'h08;
    localparam logic [7:0] ADDR_LIMIT_TWO   = 8'h0C;
    localparam logic [7:0] ADDR_PULSE_LEN   = 8'h10;
    localparam logic [7:0] ADDR_ROPE_LIFE   = 8'h14;
    localparam logic [7:0] ADDR_ROPE_WARN   = 8'h18;
    localparam logic [7:0] ADDR_LOAD_LIMIT  = 8'h1C;
    localparam logic [7:0] ADDR_STATUS      = 8'h20;

    // Field layout
    localparam int FUNC_FIELD_W     = 4;
    localparam int MAX_OUTPUTS      = 8;
    localparam int CTRL_CLOSED_LOOP = 0;
    localparam int STAT_ROPE_BIT    = 8;
    localparam int STAT_DECEL_BIT   = 9;
    localparam int STAT_LOAD_BIT    = 10;
    localparam int STAT_STILL_BIT   = 11;
    localparam int STAT_PULSE_BIT   = 12;

    // Function codes held per relay output
    localparam logic [3:0] FN_OFF            = 4'h0;
    localparam logic [3:0] FN_BRAKE_RELEASE  = 4'h1;
    localparam logic [3:0] FN_INV_LIMIT_ONE  = 4'h2;
    localparam logic [3:0] FN_INV_LIMIT_TWO  = 4'h3;
    localparam logic [3:0] FN_STANDSTILL     = 4'h4;
    localparam logic [3:0] FN_RECOVERY_STBY  = 4'h5;
    localparam logic [3:0] FN_ROPE_WEAR      = 4'h6;
    localparam logic [3:0] FN_DIR_PULSE      = 4'h7;
    localparam logic [3:0] FN_FULL_LOAD      = 4'h8;
    localparam logic [3:0] FN_DECEL_MONITOR  = 4'h9;
    localparam logic [3:0] FN_TORQUE_OFF     = 4'hA;
    localparam logic [3:0] FN_TORQUE_OFF_INV = 4'hB;
    localparam logic [3:0] FN_RECOVERY_READY = 4'hC;

    // Reset values
    localparam logic [31:0] FUNC_SEL_RESET  = 32'h0000_0000;
    localparam logic [15:0] PULSE_LEN_RESET = 16'h0FA0;

    // Timing
    localparam int FULL_LOAD_TIME_MS = 200;
    localparam int CLK_FREQ_HZ       = 40_000_000;
    localparam int FULL_LOAD_CYCLES  = FULL_LOAD_TIME_MS * (CLK_FREQ_HZ / 1000);

endpackage

// ==== drof_relay_outputs.sv ====
// Relay output function logic with a classic Wishbone register slave
//
// The address map and the Wishbone slave port were left to the implementer.
`timescale 1ns/1ps

module drof_relay_outputs
    import drof_pkg::*;
#(
    parameter int NUM_OUTPUTS  = 4,
    parameter int SPEED_W      = 16,
    parameter int CURRENT_W    = 16,
    parameter int ROPE_W       = 24,
    parameter int LOAD_CYCLES  = FULL_LOAD_CYCLES
) (
    input  wire logic                   clk,
    input  wire logic                   reset_n,
    // Wishbone slave
    input  wire logic                   wb_cyc_i,
    input  wire logic                   wb_stb_i,
    input  wire logic                   wb_we_i,
    input  wire logic [7:0]             wb_adr_i,
    input  wire logic [3:0]             wb_sel_i,
    input  wire logic [31:0]            wb_dat_i,
    output logic      [31:0]            wb_dat_o,
    output logic                        wb_ack_o,
    // Drive state
    input  wire logic                   flux_ready,
    input  wire logic [SPEED_W-1:0]     actual_speed,
    input  wire logic [SPEED_W-1:0]     commanded_speed,
    input  wire logic [CURRENT_W-1:0]   motor_current,
    input  wire logic                   constant_travel,
    input  wire logic                   decelerating,
    input  wire logic                   third_travel_speed,
    input  wire logic                   control_contactor_out,
    input  wire logic                   travel_direction,
    input  wire logic                   torque_off_blocked,
    input  wire logic                   controller_enable,
    input  wire logic                   speed_request,
    input  wire logic                   direction_request,
    input  wire logic                   rope_life_tick,
    // Contacts, high when closed
    output logic [NUM_OUTPUTS-1:0]      relay_contact
);

    // Full-load timer width; the count saturates at LOAD_DONE so it never wraps
    // while the current stays high, and the flag follows one edge later
    localparam int LOAD_W = $clog2(LOAD_CYCLES + 1);
    localparam logic [LOAD_W-1:0] LOAD_DONE = LOAD_W'(LOAD_CYCLES);

    // Whole state of the block
    // Every register lives here so that one always_ff holds them all
    typedef struct packed {
        logic [31:0]                       func_sel;
        logic                              closed_loop;
        logic [SPEED_W-1:0]                limit_one;
        logic [SPEED_W-1:0]                limit_two;
        logic [15:0]                       pulse_len;
        logic [ROPE_W-1:0]                 rope_life;
        logic [ROPE_W-1:0]                 rope_warn;
        logic [CURRENT_W-1:0]              load_limit;
        logic                              rope_latched;
        logic                              standstill;
        logic                              decel_armed;
        logic                              decel_active;
        logic [LOAD_W-1:0]                 load_count;
        logic                              full_load;
        logic                              dir_seen;
        logic                              dir_prev;
        logic [15:0]                       pulse_count;
        logic [NUM_OUTPUTS-1:0]            contact;
        logic                              ack;
        logic [31:0]                       rdata;
    } drof_state_type;

    drof_state_type r;
    drof_state_type next_r;

    // Byte-lane merge of a write into a register image
    // Lanes with a clear select keep their old bytes
    function automatic logic [31:0] wb_merge(input logic [31:0] old_val,
                                             input logic [31:0] new_val,
                                             input logic [3:0]  sel);
        logic [31:0] res;
        res = old_val;
        for (int b = 0; b < 4; b++) begin
            if (sel[b]) begin
                res[b*8 +: 8] = new_val[b*8 +: 8];
            end
        end
        return res;
    endfunction

    // Condition flags handed to the per-output decoder
    typedef struct packed {
        logic brake;
        logic over_one;
        logic over_two;
        logic standstill;
        logic standby;
        logic rope;
        logic pulse;
        logic full_load;
        logic decel;
        logic sto_free;
        logic ready;
    } drof_cond_type;

    // Contact level for one function code
    // Unused and reserved codes fall to the default and keep the contact open
    function automatic logic contact_for(input logic [3:0]     code,
                                         input drof_cond_type  c);
        logic res;
        res = 1'b0;
        case (code)
            FN_BRAKE_RELEASE:  res = c.brake;
            FN_INV_LIMIT_ONE:  res = c.over_one;
            FN_INV_LIMIT_TWO:  res = c.over_two;
            FN_STANDSTILL:     res = c.standstill;
            FN_RECOVERY_STBY:  res = c.standby;
            FN_ROPE_WEAR:      res = c.rope;
            FN_DIR_PULSE:      res = c.pulse;
            FN_FULL_LOAD:      res = c.full_load;
            FN_DECEL_MONITOR:  res = c.decel;
            FN_TORQUE_OFF:     res = c.sto_free;
            FN_TORQUE_OFF_INV: res = !c.sto_free;
            FN_RECOVERY_READY: res = c.ready;
            default:           res = 1'b0;
        endcase
        return res;
    endfunction

    logic [31:0]        status_word;
    logic [SPEED_W-1:0] decel_speed;
    drof_cond_type      cond;

    // Status image and monitored speed source
    always_comb begin
        status_word = '0;
        status_word[NUM_OUTPUTS-1:0] = r.contact;
        status_word[STAT_ROPE_BIT]   = r.rope_latched;
        status_word[STAT_DECEL_BIT]  = r.decel_active;
        status_word[STAT_LOAD_BIT]   = r.full_load;
        status_word[STAT_STILL_BIT]  = r.standstill;
        status_word[STAT_PULSE_BIT]  = (r.pulse_count != '0);
        decel_speed = r.closed_loop ? actual_speed : commanded_speed;
    end

    // Next-state logic
    always_comb begin
        logic        wr;
        logic        rd;
        logic [31:0] wimg;
        wr   = 1'b0;
        rd   = 1'b0;
        wimg = '0;
        next_r       = r;
        next_r.ack   = 1'b0;
        next_r.rdata = '0;

        // Bus access, answered one cycle after the strobe
        // No new access while ack is high, so a held strobe is never answered twice in a row
        if (wb_cyc_i && wb_stb_i && !r.ack) begin
            next_r.ack = 1'b1;
            wr = wb_we_i;
            rd = !wb_we_i;
        end

        // Standstill contact: open on motion, close at zero with contactor off
        // Between the two events the flag keeps its state, so a stop with the
        // contactor still pulled in does not close the contact early
        if (actual_speed != '0) begin
            next_r.standstill = 1'b0;
        end else if (!control_contactor_out) begin
            next_r.standstill = 1'b1;
        end

        // Rope life down-counter with latched warning
        // A reload write further down wins over a latch in the same cycle; if the new
        // value is still at or under the warning level the latch sets one edge later
        if (rope_life_tick && r.rope_life != '0) begin
            next_r.rope_life = r.rope_life - ROPE_W'(1);
        end
        if (r.rope_life <= r.rope_warn) begin
            next_r.rope_latched = 1'b1;
        end

        // Full-load timer: current over limit continuously at constant speed
        // Any gap in the condition restarts the count, so short peaks never close it
        // The flag is read from the registered count and drops one edge after a gap
        if (constant_travel && motor_current > r.load_limit) begin
            if (r.load_count != LOAD_DONE) begin
                next_r.load_count = r.load_count + LOAD_W'(1);
            end
        end else begin
            next_r.load_count = '0;
        end
        next_r.full_load = (r.load_count == LOAD_DONE);

        // Deceleration monitor from the third travel speed
        // Arming is remembered so the monitor stays live for the whole deceleration,
        // even if the third-speed flag drops before the speed passes limit one
        if (decelerating && third_travel_speed) begin
            next_r.decel_armed = 1'b1;
        end
        if (decel_speed == '0) begin
            next_r.decel_armed  = 1'b0;
            next_r.decel_active = 1'b0;
        end else if (r.decel_armed && decelerating && decel_speed < r.limit_one) begin
            next_r.decel_active = 1'b1;
        end

        // Direction change pulse, one per edge of the direction level
        // dir_seen masks the first edge after reset: dir_prev starts at zero and would
        // otherwise report a change whenever the pin idles high
        // A change during a running pulse restarts it from pulse_len
        next_r.dir_seen = 1'b1;
        next_r.dir_prev = travel_direction;
        if (r.dir_seen && travel_direction != r.dir_prev) begin
            next_r.pulse_count = r.pulse_len;
        end else if (r.pulse_count != '0) begin
            next_r.pulse_count = r.pulse_count - 16'h0001;
        end

        // Register writes
        if (wr) begin
            unique case (wb_adr_i)
                ADDR_FUNC_SEL: begin
                    next_r.func_sel = wb_merge(r.func_sel, wb_dat_i, wb_sel_i);
                end
                ADDR_CTRL: begin
                    wimg = wb_merge({31'h0, r.closed_loop}, wb_dat_i, wb_sel_i);
                    next_r.closed_loop = wimg[CTRL_CLOSED_LOOP];
                end
                ADDR_LIMIT_ONE: begin
                    wimg = wb_merge(32'(r.limit_one), wb_dat_i, wb_sel_i);
                    next_r.limit_one = wimg[SPEED_W-1:0];
                end
                ADDR_LIMIT_TWO: begin
                    wimg = wb_merge(32'(r.limit_two), wb_dat_i, wb_sel_i);
                    next_r.limit_two = wimg[SPEED_W-1:0];
                end
                ADDR_PULSE_LEN: begin
                    wimg = wb_merge(32'(r.pulse_len), wb_dat_i, wb_sel_i);
                    next_r.pulse_len = wimg[15:0];
                end
                ADDR_ROPE_LIFE: begin
                    // Reloading the counter releases the latched warning
                    wimg = wb_merge(32'(r.rope_life), wb_dat_i, wb_sel_i);
                    next_r.rope_life    = wimg[ROPE_W-1:0];
                    next_r.rope_latched = 1'b0;
                end
                ADDR_ROPE_WARN: begin
                    wimg = wb_merge(32'(r.rope_warn), wb_dat_i, wb_sel_i);
                    next_r.rope_warn = wimg[ROPE_W-1:0];
                end
                ADDR_LOAD_LIMIT: begin
                    wimg = wb_merge(32'(r.load_limit), wb_dat_i, wb_sel_i);
                    next_r.load_limit = wimg[CURRENT_W-1:0];
                end
                default: begin
                end
            endcase
        end

        // Register reads; unmapped addresses read zero
        // Read data stands for the ack cycle only and is zero otherwise
        if (rd) begin
            unique case (wb_adr_i)
                ADDR_FUNC_SEL:   next_r.rdata = r.func_sel;
                ADDR_CTRL:       next_r.rdata = {31'h0, r.closed_loop};
                ADDR_LIMIT_ONE:  next_r.rdata = 32'(r.limit_one);
                ADDR_LIMIT_TWO:  next_r.rdata = 32'(r.limit_two);
                ADDR_PULSE_LEN:  next_r.rdata = 32'(r.pulse_len);
                ADDR_ROPE_LIFE:  next_r.rdata = 32'(r.rope_life);
                ADDR_ROPE_WARN:  next_r.rdata = 32'(r.rope_warn);
                ADDR_LOAD_LIMIT: next_r.rdata = 32'(r.load_limit);
                ADDR_STATUS:     next_r.rdata = status_word;
                default:         next_r.rdata = 32'h0000_0000;
            endcase
        end

        // Condition flags for the contacts
        // Input-driven flags come straight from the pins and reach the contact one edge
        // later; flags kept in the state register add one more edge
        cond.brake      = flux_ready;
        cond.over_one   = actual_speed > r.limit_one;
        cond.over_two   = actual_speed > r.limit_two;
        cond.standstill = r.standstill;
        cond.standby    = !controller_enable;
        cond.rope       = r.rope_latched;
        cond.pulse      = (r.pulse_count != '0);
        cond.full_load  = r.full_load;
        cond.decel      = r.decel_active;
        cond.sto_free   = !torque_off_blocked;
        cond.ready      = controller_enable && speed_request && direction_request;

        // One registered contact per output from its function code
        // Output i takes its code from bits 4i+3 down to 4i of the selection word
        for (int i = 0; i < NUM_OUTPUTS; i++) begin
            next_r.contact[i] = contact_for(r.func_sel[i*FUNC_FIELD_W +: FUNC_FIELD_W],
                                            cond);
        end
    end

    // State register
    // Synchronous reset; all codes return to off, so every contact opens
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            r           <= '0;
            r.func_sel  <= FUNC_SEL_RESET;
            r.pulse_len <= PULSE_LEN_RESET;
        end else begin
            r <= next_r;
        end
    end

    // Outputs straight from the state register
    // No logic between flip-flop and pin, so the contacts never glitch
    assign wb_ack_o      = r.ack;
    assign wb_dat_o      = r.rdata;
    assign relay_contact = r.contact;

endmodule // drof_relay_outputs

// ==== drof_lift_partner.sv ====
// Model of the brake contactor and mechanical brake behind one relay contact
`timescale 1ns/1ps
module drof_lift_partner (
    input  wire logic clk,
    input  wire logic reset_n,
    input  wire logic brake_contact,
    output logic      brake_open
);
    // Contactor pulls in on the edge after the contact closes, lifting the brake
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            brake_open <= 1'b0;
        end else begin
            brake_open <= brake_contact;
        end
    end
endmodule // drof_lift_partner

// ==== drof_relay_assertions.sv ====
// Concurrent checks on the ports of the relay output block
`timescale 1ns/1ps
module drof_relay_checker
    import drof_pkg::*;
#(
    parameter int NUM_OUTPUTS = 4,
    parameter int SPEED_W     = 16
) (
    input wire logic                   clk,
    input wire logic                   reset_n,
    input wire logic                   wb_cyc_i,
    input wire logic                   wb_stb_i,
    input wire logic                   wb_we_i,
    input wire logic [7:0]             wb_adr_i,
    input wire logic [3:0]             wb_sel_i,
    input wire logic [31:0]            wb_dat_i,
    input wire logic                   wb_ack_o,
    input wire logic                   flux_ready,
    input wire logic [SPEED_W-1:0]     actual_speed,
    input wire logic                   control_contactor_out,
    input wire logic                   travel_direction,
    input wire logic                   torque_off_blocked,
    input wire logic                   controller_enable,
    input wire logic                   speed_request,
    input wire logic                   direction_request,
    input wire logic [NUM_OUTPUTS-1:0] relay_contact
);
    logic [3:0]  c0;
    logic [15:0] lim1;
    logic [15:0] plen;
    logic        wr;
    logic        reload;
    assign wr     = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o;
    assign reload = wr && wb_adr_i == ADDR_ROPE_LIFE;
    // Mirror of output 0 code, limit one and pulse length; only full-word writes tracked
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            c0   <= FN_OFF;
            lim1 <= 16'h0000;
            plen <= PULSE_LEN_RESET;
        end else if (wr && wb_sel_i == 4'hF) begin
            if (wb_adr_i == ADDR_FUNC_SEL) c0 <= wb_dat_i[3:0];
            if (wb_adr_i == ADDR_LIMIT_ONE) lim1 <= wb_dat_i[15:0];
            if (wb_adr_i == ADDR_PULSE_LEN) plen <= wb_dat_i[15:0];
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    property p_brake;
        $past(reset_n) && $past(c0) == FN_BRAKE_RELEASE |-> relay_contact[0] == $past(flux_ready);
    endproperty
    a_brake: assert property (p_brake) else $error("brake contact wrong");
    property p_inv_one;
        $past(reset_n) && $past(c0) == FN_INV_LIMIT_ONE
            |-> relay_contact[0] == ($past(actual_speed) > $past(lim1));
    endproperty
    a_inv_one: assert property (p_inv_one) else $error("limit one contact wrong");
    property p_still_open;
        actual_speed != 0 ##1 c0 == FN_STANDSTILL |=> !relay_contact[0];
    endproperty
    a_still_open: assert property (p_still_open) else $error("standstill not open");
    property p_still_close;
        actual_speed == 0 && !control_contactor_out ##1 c0 == FN_STANDSTILL |=> relay_contact[0];
    endproperty
    a_still_close: assert property (p_still_close) else $error("standstill not closed");
    property p_pulse;
        $past(reset_n, 2) && c0 == FN_DIR_PULSE && plen == 16'd5 && $changed(travel_direction)
            |-> ##2 relay_contact[0] [*5] ##1 !relay_contact[0];
    endproperty
    a_pulse: assert property (p_pulse) else $error("direction pulse wrong");
    property p_rope_hold;
        c0 == FN_ROPE_WEAR && relay_contact[0] && !$past(reload) |=> relay_contact[0];
    endproperty
    a_rope_hold: assert property (p_rope_hold) else $error("rope contact released");
    property p_sto;
        $past(reset_n) && $past(c0) == FN_TORQUE_OFF
            |-> relay_contact[0] == !$past(torque_off_blocked);
    endproperty
    a_sto: assert property (p_sto) else $error("torque-off status wrong");
    property p_sto_inv;
        $past(reset_n) && $past(c0) == FN_TORQUE_OFF_INV
            |-> relay_contact[0] == $past(torque_off_blocked);
    endproperty
    a_sto_inv: assert property (p_sto_inv) else $error("inverted status wrong");
    property p_ready;
        $past(reset_n) && $past(c0) == FN_RECOVERY_READY |-> relay_contact[0]
            == $past(controller_enable && speed_request && direction_request);
    endproperty
    a_ready: assert property (p_ready) else $error("recovery ready wrong");
    property p_off;
        $past(reset_n) && ($past(c0) == FN_OFF || $past(c0) > FN_RECOVERY_READY)
            |-> !relay_contact[0];
    endproperty
    a_off: assert property (p_off) else $error("unassigned contact closed");
    c_pulse: cover property (c0 == FN_DIR_PULSE && relay_contact[0]);
    c_rope: cover property (c0 == FN_ROPE_WEAR && relay_contact[0]);
    c_ack: cover property (wb_ack_o);
endmodule // drof_relay_checker
bind drof_relay_outputs drof_relay_checker #(.NUM_OUTPUTS(NUM_OUTPUTS), .SPEED_W(SPEED_W))
    u_drof_relay_checker (.clk(clk), .reset_n(reset_n), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_ack_o(wb_ack_o), .flux_ready(flux_ready),
    .actual_speed(actual_speed), .control_contactor_out(control_contactor_out),
    .travel_direction(travel_direction), .torque_off_blocked(torque_off_blocked),
    .controller_enable(controller_enable), .speed_request(speed_request),
    .direction_request(direction_request), .relay_contact(relay_contact));

// ==== testbench.sv ====
// Self-checking bench for the relay output function block
`timescale 1ns/1ps
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin miscompares++; \
    $display("BAD t=%0t got=%h exp=%h", $time, g, e); end end
module testbench;
    import drof_pkg::*;
    logic        clk = 0, reset_n = 0, cyc = 0, we = 0, ack, brake_open;
    logic [7:0]  adr = 0;
    logic [31:0] wdat = 0, rdat, dat_o;
    logic        flux = 0, cons = 0, dec = 0, third = 0, ctc = 0, dir = 0;
    logic        blk = 0, en = 0, sreq = 0, dreq = 0, tick = 0;
    logic [15:0] spd = 0, cmd = 0, cur = 0;
    logic [3:0]  rc;
    logic [3:0]  codes [9] = '{FN_OFF, FN_BRAKE_RELEASE, FN_INV_LIMIT_ONE, FN_INV_LIMIT_TWO,
        FN_RECOVERY_STBY, FN_TORQUE_OFF, FN_TORQUE_OFF_INV, FN_RECOVERY_READY, 4'hE};
    int          miscompares = 0, n_compared = 0, hi;
    always #12.5 clk = ~clk;
    drof_relay_outputs #(.LOAD_CYCLES(20)) u_drof_relay_outputs (.clk(clk), .reset_n(reset_n),
        .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF),
        .wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack), .flux_ready(flux),
        .actual_speed(spd), .commanded_speed(cmd), .motor_current(cur),
        .constant_travel(cons), .decelerating(dec), .third_travel_speed(third),
        .control_contactor_out(ctc), .travel_direction(dir), .torque_off_blocked(blk),
        .controller_enable(en), .speed_request(sreq), .direction_request(dreq),
        .rope_life_tick(tick), .relay_contact(rc));
    drof_lift_partner u_drof_lift_partner (.clk(clk), .reset_n(reset_n),
        .brake_contact(rc[1]), .brake_open(brake_open));
    // One classic bus cycle; ack and read data are taken at the edge that samples ack high
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        cyc  <= 1'b1;
        we   <= w;
        adr  <= a;
        wdat <= d;
        do begin
            @(posedge clk);
        end while (ack !== 1'b1);
        rdat = dat_o;
        cyc <= 1'b0;
        @(posedge clk);
    endtask
    // Let n edges pass, compare the contacts mid-cycle, return just after an edge
    task automatic look(input int n, input logic [3:0] e);
        repeat (n) @(posedge clk);
        @(negedge clk);
        `CHK(rc, e)
        @(posedge clk);
    endtask
    // Expected contact for the input-driven functions
    function automatic logic exp_fn(input logic [3:0] c);
        case (c)
            FN_BRAKE_RELEASE:  return flux;
            FN_INV_LIMIT_ONE:  return spd > 16'd40;
            FN_INV_LIMIT_TWO:  return spd > 16'd90;
            FN_RECOVERY_STBY:  return !en;
            FN_TORQUE_OFF:     return !blk;
            FN_TORQUE_OFF_INV: return blk;
            FN_RECOVERY_READY: return en && sreq && dreq;
            default:           return 1'b0;
        endcase
    endfunction
    task automatic print_verdict();
        $display("compared %0d mismatches %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    // Watchdog against a hung handshake
    initial begin
        repeat (6000) @(posedge clk);
        miscompares++;
        print_verdict();
    end
    initial begin
        void'($urandom(32'hF0947A70));
        repeat (8) @(posedge clk);
        reset_n <= 1;
        @(posedge clk);
        bus(0, ADDR_PULSE_LEN, 0);
        `CHK(rdat, 32'h0000_0FA0)
        bus(0, ADDR_FUNC_SEL, 0);
        `CHK(rdat, 32'h0)
        bus(1, 8'h30, 32'hFFFF_FFFF);
        bus(0, 8'h30, 0);
        `CHK(rdat, 32'h0)
        look(1, 4'h0);
        $display("test reset done");
        bus(1, ADDR_LIMIT_ONE, 40);
        bus(1, ADDR_LIMIT_TWO, 90);
        bus(1, ADDR_PULSE_LEN, 5);
        foreach (codes[k]) begin
            bus(1, ADDR_FUNC_SEL, 32'({4{codes[k]}}));
            repeat (12) begin
                {flux, blk, en, sreq, dreq} <= 5'($urandom);
                spd <= 16'($urandom_range(0, 120));
                repeat (2) @(posedge clk);
                @(negedge clk);
                `CHK(rc, {4{exp_fn(codes[k])}})
                if (codes[k] == FN_BRAKE_RELEASE) `CHK(brake_open, flux)
                @(posedge clk);
            end
        end
        $display("test input functions done");
        bus(1, ADDR_FUNC_SEL, 32'({4{FN_STANDSTILL}}));
        spd <= 0;
        look(3, 4'hF);
        spd <= 7;
        ctc <= 1;
        look(3, 4'h0);
        spd <= 0;
        look(3, 4'h0);
        ctc <= 0;
        look(3, 4'hF);
        bus(1, ADDR_FUNC_SEL, 32'({4{FN_DIR_PULSE}}));
        dir <= ~dir;
        hi = 0;
        repeat (12) begin
            @(negedge clk);
            hi += (rc === 4'hF);
        end
        `CHK(hi, 5)
        @(posedge clk);
        $display("test standstill and pulse done");
        bus(1, ADDR_LOAD_LIMIT, 100);
        bus(1, ADDR_FUNC_SEL, 32'({4{FN_FULL_LOAD}}));
        cons <= 1;
        cur <= 200;
        look(17, 4'h0);
        cur <= 50;
        @(posedge clk);
        cur <= 200;
        look(15, 4'h0);
        look(8, 4'hF);
        cons <= 0;
        look(3, 4'h0);
        bus(1, ADDR_CTRL, 1);
        bus(1, ADDR_FUNC_SEL, 32'({4{FN_DECEL_MONITOR}}));
        {dec, third, spd, cmd} <= {2'b11, 16'd100, 16'd100};
        look(3, 4'h0);
        spd <= 30;
        look(3, 4'hF);
        spd <= 0;
        look(3, 4'h0);
        bus(1, ADDR_CTRL, 0);
        spd <= 100;
        look(3, 4'h0);
        cmd <= 30;
        look(3, 4'hF);
        cmd <= 0;
        look(3, 4'h0);
        $display("test load and decel done");
        bus(1, ADDR_ROPE_WARN, 3);
        bus(1, ADDR_ROPE_LIFE, 5);
        bus(1, ADDR_FUNC_SEL, 32'({4{FN_ROPE_WEAR}}));
        look(3, 4'h0);
        tick <= 1;
        repeat (2) @(posedge clk);
        tick <= 0;
        look(3, 4'hF);
        bus(1, ADDR_ROPE_WARN, 32'h0000_0000); // Life above warning now, only the latch holds
        look(6, 4'hF);
        bus(1, ADDR_ROPE_LIFE, 10);
        look(3, 4'h0);
        $display("test rope done");
        print_verdict();
    end
endmodule // testbench
